// >>> design/crp_supervisor.sv
/*
 * Core rail protection supervisor: offsets, voltage-change phase handling,
 * strap decode, current monitor conversion, quick response and fault FSMs.
 * Assumes comparator levels and pins are synchronous to clk_i, analog levels
 * digitised in mV (the current monitor pin in quarter mV), and a classic Wishbone master on the register port.
 */
`default_nettype none
module crp_supervisor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic enable_i,
    input wire logic supply_ok_i,
    input wire logic [11:0] core_offset_input_i,
    input wire logic [11:0] second_rail_offset_input_i,
    input wire logic core_external_shift_enable_i,
    input wire logic second_rail_external_shift_enable_i,
    input wire logic [1:0] config_strap_a_i,
    input wire logic [1:0] config_strap_b_i,
    input wire logic dynamic_voltage_change_up_i,
    input wire logic dynamic_voltage_change_down_i,
    input wire logic dynamic_voltage_change_done_i,
    input wire logic diode_emulation_mode_i,
    input wire logic [2:0] active_phases_i,
    input wire logic [13:0] current_monitor_pin_i,
    input wire logic [8:0] cycle_current_i,
    input wire logic quick_response_i,
    input wire logic [7:0] on_time_cyc_i,
    input wire logic [2:0] per_phase_overcurrent_trip_i,
    input wire logic signed [15:0] output_sense_pin_i,
    input wire logic signed [15:0] reference_i,
    input wire logic signed [15:0] voltage_code_i,
    input wire logic other_rail_fault_i,
    input wire logic [2:0] pwm_high_i,
    input wire logic [2:0] pwm_low_i,
    output logic [2:0] high_side_on_o,
    output logic [2:0] low_side_on_o,
    output logic [2:0] on_time_override_o,
    output logic overcurrent_alert_n_o,
    output logic other_rail_shutdown_o,
    output logic soft_shutdown_o,
    output logic force_three_phase_o,
    output logic [3:0] voltage_change_comp_bits_o,
    output logic [1:0] ramp_amplitude_o,
    output logic ramp_dem_o,
    output logic signed [15:0] core_offset_o,
    output logic signed [15:0] second_rail_offset_o,
    output logic [8:0] output_current_o
);
    import crp_pkg::*;

    // Two strap bits pick one of four settings
    function automatic logic [1:0] strap_code(input logic [1:0] s);
        strap_code = {s[1], s[0] ^ s[1]};
    endfunction

    logic enable_q;
    logic en_rise;
    logic supply_q;
    logic clear_faults;
    logic init_ofs_ok_q;
    logic ext_core_q;
    logic ext_second_q;
    logic [1:0] strap_a_q;
    logic [1:0] strap_b_q;
    logic signed [15:0] init_ofs_q;
    logic [8:0] spike_thr_q;
    logic [1:0] tdc_sel_q;
    logic [8:0] iout_q;
    logic [15:0] adc_div_q;
    logic adc_tick;
    logic [8:0] adc_code;
    logic [6:0] tdc_pct;
    logic [15:0] tdc_prod;
    logic [8:0] tdc_thr;
    logic tdc_over;
    logic tdc_hit;
    logic spike_over;
    logic oc_fire;
    crp_oc_state_t oc_state_q;
    crp_oc_state_t oc_state_d;
    logic [15:0] oc_cnt_q;
    logic phase_oc_q;
    logic ov_cond;
    logic ov_hit;
    logic ov_q;
    logic nv_q;
    logic uv_cond;
    logic uv_hit;
    logic uv_q;
    logic lock_hit;
    logic lockout_q;
    logic force_q;
    logic qr_pulse;
    logic all_off;
    logic [2:0] phases;
    logic ack_q;
    logic [31:0] rdata_q;
    logic wb_req;

    assign en_rise = enable_i && !enable_q;
    // New power-on (supply recovers) or enable rise clears latches
    assign clear_faults = en_rise || (supply_ok_i && !supply_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= 1'b0;
            supply_q <= 1'b0;
        end else begin
            enable_q <= enable_i;
            supply_q <= supply_ok_i;
        end
    end

    // Pin and strap capture at enable rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_ofs_ok_q <= 1'b0;
            ext_core_q <= 1'b0;
            ext_second_q <= 1'b0;
            strap_a_q <= 2'h0;
            strap_b_q <= 2'h0;
        end else if (en_rise) begin
            init_ofs_ok_q <= (core_offset_input_i >= 12'(INIT_OFS_MIN_MV));
            // Mixed strap settings are not defined and leave offset disabled
            ext_core_q <= core_external_shift_enable_i
                && second_rail_external_shift_enable_i;
            ext_second_q <= core_external_shift_enable_i
                && second_rail_external_shift_enable_i;
            strap_a_q <= config_strap_a_i;
            strap_b_q <= config_strap_b_i;
        end
    end

    // Target offsets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_offset_o <= 16'sh0000;
            second_rail_offset_o <= 16'sh0000;
        end else begin
            core_offset_o <= (init_ofs_ok_q ? init_ofs_q : 16'sh0000)
                + (ext_core_q ? ($signed({4'h0, core_offset_input_i})
                - 16'(EXT_OFS_BASE_MV)) : 16'sh0000);
            second_rail_offset_o <= ext_second_q
                ? ($signed({4'h0, second_rail_offset_input_i})
                - 16'(EXT_OFS_BASE_MV)) : 16'sh0000;
        end
    end

    // Strap decode for compensation and ramp
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            voltage_change_comp_bits_o <= 4'h0;
            ramp_amplitude_o <= 2'h0;
            ramp_dem_o <= 1'b0;
        end else begin
            voltage_change_comp_bits_o <= {strap_code(strap_b_q),
                strap_code(strap_a_q)};
            ramp_amplitude_o <= strap_code(strap_a_q);
            ramp_dem_o <= diode_emulation_mode_i;
        end
    end

    // Upward change forces three phases until the change completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_q <= 1'b0;
        end else if (dynamic_voltage_change_up_i) begin
            force_q <= 1'b1;
        end else if (dynamic_voltage_change_done_i) begin
            force_q <= 1'b0;
        end
    end
    // A downward change leaves force_q and the phase mask untouched
    assign phases = force_q ? 3'b111 : active_phases_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_three_phase_o <= 1'b0;
        end else begin
            force_three_phase_o <= force_q;
        end
    end

    // Current monitor converter, sampled on a divided tick
    assign adc_tick = (adc_div_q == 16'(ADC_PERIOD_CYC - 1));
    assign adc_code = (current_monitor_pin_i >= 14'(ADC_FULL_QMV))
        ? ADC_MAX_CODE
        : 9'(current_monitor_pin_i / 14'(ADC_STEP_QMV));

    always_ff @(posedge clk_i) begin
        if (rst_i || adc_tick) begin
            adc_div_q <= 16'h0000;
        end else begin
            adc_div_q <= adc_div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iout_q <= 9'h000;
        end else if (adc_tick) begin
            iout_q <= adc_code;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_current_o <= 9'h000;
        end else begin
            output_current_o <= iout_q;
        end
    end

    // Quick response
    crp_qr_pulse u_qr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .trig_i(quick_response_i),
        .on_time_cyc_i(on_time_cyc_i),
        .pulse_o(qr_pulse)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_time_override_o <= 3'h0;
        end else begin
            on_time_override_o <= qr_pulse ? phases : 3'h0;
        end
    end

    // Dual overcurrent
    always_comb begin
        case (tdc_sel_q)
            2'h0: tdc_pct = TDC_PCT_0;
            2'h1: tdc_pct = TDC_PCT_1;
            2'h2: tdc_pct = TDC_PCT_2;
            default: tdc_pct = TDC_PCT_3;
        endcase
    end
    assign tdc_prod = 16'(spike_thr_q * tdc_pct);
    assign tdc_thr = 9'(tdc_prod / 16'(PCT_DIV));
    assign tdc_over = (iout_q > tdc_thr);
    assign spike_over = (cycle_current_i > spike_thr_q);

    crp_persist_filter #(
        .COUNT(TRIGGER_DELAY_CYC)
    ) u_tdc_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(tdc_over),
        .hit_o(tdc_hit)
    );

    assign oc_fire = tdc_hit || spike_over;

    always_comb begin
        oc_state_d = oc_state_q;
        case (oc_state_q)
            OC_IDLE: begin
                if (oc_fire) begin
                    oc_state_d = OC_WAIT;
                end
            end
            OC_WAIT: begin
                if (oc_cnt_q == 16'(OC_WAIT_CYC - 1)) begin
                    oc_state_d = (tdc_over || spike_over) ? OC_SHUT : OC_IDLE;
                end
            end
            OC_SHUT: oc_state_d = OC_SHUT;
            default: oc_state_d = OC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_faults) begin
            oc_state_q <= OC_IDLE;
        end else begin
            oc_state_q <= oc_state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || oc_state_q != OC_WAIT) begin
            oc_cnt_q <= 16'h0000;
        end else begin
            oc_cnt_q <= oc_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overcurrent_alert_n_o <= 1'b1;
        end else begin
            overcurrent_alert_n_o <= !(oc_state_d != OC_IDLE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || (clear_faults && !(|per_phase_overcurrent_trip_i))) begin
            phase_oc_q <= 1'b0;
        end else if (|per_phase_overcurrent_trip_i) begin
            phase_oc_q <= 1'b1;
        end
    end

    // Overvoltage with filter and negative-voltage guard
    assign ov_cond = (voltage_code_i < 16'(OV_LOW_CODE_MV))
        ? (output_sense_pin_i > 16'(OV_LOW_CODE_MV + OV_MARGIN_MV))
        : (output_sense_pin_i > reference_i + 16'(OV_MARGIN_MV));

    crp_persist_filter #(
        .COUNT(OV_FILTER_CYC)
    ) u_ov_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(ov_cond && supply_ok_i),
        .hit_o(ov_hit)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || (clear_faults && !ov_hit)) begin
            ov_q <= 1'b0;
        end else if (ov_hit) begin
            ov_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ov_q) begin
            nv_q <= 1'b0;
        end else begin
            nv_q <= (output_sense_pin_i < 16'(NV_LEVEL_MV));
        end
    end

    // Undervoltage
    assign uv_cond = (output_sense_pin_i <= reference_i - 16'(UV_MARGIN_MV));

    crp_persist_filter #(
        .COUNT(UV_FILTER_CYC)
    ) u_uv_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(uv_cond && supply_ok_i),
        .hit_o(uv_hit)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || (clear_faults && !uv_hit)) begin
            uv_q <= 1'b0;
        end else if (uv_hit) begin
            uv_q <= 1'b1;
        end
    end

    // Supply lockout
    crp_persist_filter #(
        .COUNT(LOCKOUT_FILTER_CYC)
    ) u_lock_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(!supply_ok_i),
        .hit_o(lock_hit)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || supply_ok_i) begin
            lockout_q <= 1'b0;
        end else if (lock_hit) begin
            lockout_q <= 1'b1;
        end
    end

    // Cross-rail shutdown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            other_rail_shutdown_o <= 1'b0;
            soft_shutdown_o <= 1'b0;
        end else begin
            other_rail_shutdown_o <= ov_q || uv_q;
            soft_shutdown_o <= other_rail_fault_i;
        end
    end

    // Gate outputs
    assign all_off = lockout_q || uv_q || phase_oc_q || (oc_state_q == OC_SHUT)
        || !enable_i;

    always_ff @(posedge clk_i) begin
        if (rst_i || all_off) begin
            high_side_on_o <= 3'h0;
            low_side_on_o <= 3'h0;
        end else if (ov_q) begin
            high_side_on_o <= 3'h0;
            low_side_on_o <= nv_q ? 3'h0 : phases;
        end else if (other_rail_fault_i) begin
            high_side_on_o <= 3'h0;
            low_side_on_o <= 3'h0;
        end else begin
            high_side_on_o <= pwm_high_i & phases;
            low_side_on_o <= pwm_low_i & phases;
        end
    end

    // Wishbone classic slave, one wait state
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_ofs_q <= INIT_OFS_RST;
            spike_thr_q <= SPIKE_THR_RST;
            tdc_sel_q <= TDC_SEL_RST;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == ADR_INIT_OFS) begin
                if (wb_sel_i[0]) begin
                    init_ofs_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    init_ofs_q[15:8] <= wb_dat_i[15:8];
                end
            end
            if (wb_adr_i == ADR_OC_CFG) begin
                if (wb_sel_i[0]) begin
                    spike_thr_q[7:0] <= wb_dat_i[OC_CFG_SPIKE_LSB +: 8];
                end
                if (wb_sel_i[1]) begin
                    spike_thr_q[8] <= wb_dat_i[OC_CFG_SPIKE_LSB + 8];
                end
                if (wb_sel_i[2]) begin
                    tdc_sel_q <= wb_dat_i[OC_CFG_TDC_LSB +: 2];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_INIT_OFS: rdata_q <= {16'h0000, init_ofs_q};
                ADR_OC_CFG: rdata_q <= {14'h0000, tdc_sel_q, 7'h00, spike_thr_q};
                ADR_STATUS: rdata_q <= {18'h00000, strap_b_q, strap_a_q,
                    init_ofs_ok_q, ext_core_q, force_q, lockout_q,
                    nv_q, uv_q, ov_q, phase_oc_q, oc_state_q == OC_SHUT,
                    !overcurrent_alert_n_o};
                ADR_IOUT: rdata_q <= {23'h000000, iout_q};
                ADR_OFFSET: rdata_q <= {16'h0000, core_offset_o};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
endmodule // crp_supervisor
`default_nettype wire

// >>> design/crp_pkg.sv
/*
 * Shared constants for the core rail protection supervisor: register map,
 * reset values, filter and delay times, voltage limits and FSM encodings.
 * Assumes a 100 MHz clock; analog levels arrive already digitised in mV, the current monitor in quarter mV.
 */
`default_nettype none
package crp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Times in ns, cycle counts derived (least times round up)
    localparam int OV_FILTER_NS = 1000;
    localparam int UV_FILTER_NS = 3000;
    localparam int LOCKOUT_FILTER_NS = 3000;
    localparam int TRIGGER_DELAY_NS = 10000;
    localparam int ACTION_DELAY_NS = 5000;
    localparam int SETTLE_NS = 1000;
    localparam int ADC_PERIOD_NS = 1000;
    localparam int OV_FILTER_CYC = (OV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCKOUT_FILTER_CYC =
        (LOCKOUT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIGGER_DELAY_CYC =
        (TRIGGER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_WAIT_CYC =
        (ACTION_DELAY_NS + SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADC_PERIOD_CYC = ADC_PERIOD_NS / CLK_PERIOD_NS;
    // Voltage levels in mV
    localparam int INIT_OFS_MIN_MV = 300;
    localparam int EXT_OFS_BASE_MV = 1200;
    localparam int OV_LOW_CODE_MV = 900;
    localparam int OV_MARGIN_MV = 325;
    localparam int UV_MARGIN_MV = 500;
    localparam int NV_LEVEL_MV = 0;
    // Current monitor converter, input in quarter mV
    localparam int ADC_STEP_QMV = 25;
    localparam int ADC_FULL_QMV = 12775;
    localparam logic [8:0] ADC_MAX_CODE = 9'h1ff;
    // Register byte offsets
    localparam logic [7:0] ADR_INIT_OFS = 8'h00;
    localparam logic [7:0] ADR_OC_CFG = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_IOUT = 8'h0c;
    localparam logic [7:0] ADR_OFFSET = 8'h10;
    // Field positions
    localparam int OC_CFG_SPIKE_LSB = 0;
    localparam int OC_CFG_TDC_LSB = 16;
    // Reset values
    localparam logic [15:0] INIT_OFS_RST = 16'h0000;
    localparam logic [8:0] SPIKE_THR_RST = 9'h1ff;
    localparam logic [1:0] TDC_SEL_RST = 2'h3;
    // Sustained threshold as percent of peak threshold
    localparam logic [6:0] TDC_PCT_0 = 7'h3c;
    localparam logic [6:0] TDC_PCT_1 = 7'h46;
    localparam logic [6:0] TDC_PCT_2 = 7'h50;
    localparam logic [6:0] TDC_PCT_3 = 7'h5a;
    localparam int PCT_DIV = 100;
    typedef enum logic [2:0] {
        OC_IDLE = 3'b001,
        OC_WAIT = 3'b010,
        OC_SHUT = 3'b100
    } crp_oc_state_t;
endpackage
`default_nettype wire

// >>> design/crp_persist_filter.sv
/*
 * Persistence filter: hit_o rises once cond_i has held for COUNT cycles.
 * Assumes cond_i is synchronous to clk_i.
 */
`default_nettype none
module crp_persist_filter #(
    parameter int COUNT = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cond_i,
    output logic hit_o
);
    logic [15:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !cond_i) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q != 16'(COUNT)) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign hit_o = cond_i && (cnt_q == 16'(COUNT));
endmodule // crp_persist_filter
`default_nettype wire

// >>> design/crp_qr_pulse.sv
/*
 * Quick-response pulse generator: one pulse per trigger, width set by the
 * nominal on-time in clock cycles. Retriggers are ignored while busy.
 */
`default_nettype none
module crp_qr_pulse (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic trig_i,
    input wire logic [7:0] on_time_cyc_i,
    output logic pulse_o
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (trig_i && on_time_cyc_i != 8'h00) begin
            cnt_q <= on_time_cyc_i;
        end
    end

    assign pulse_o = (cnt_q != 8'h00);
endmodule // crp_qr_pulse
`default_nettype wire

// >>> verif/crp_stage_model.sv
/* Far-side stand-in: modulator gate requests and phase mask.
   Assumes all three phases are populated. */
`default_nettype none
module crp_stage_model (
    output var logic [2:0] pwm_high_o,
    output var logic [2:0] pwm_low_o,
    output var logic [2:0] phases_o
);
    assign pwm_high_o = 3'h5;
    assign pwm_low_o = 3'h2;
    assign phases_o = 3'h7;
endmodule // crp_stage_model
`default_nettype wire

// >>> verif/crp_supervisor_props.sv
/* Concurrent checks on the supervisor ports.
   Assumes one clock and the synchronous reset. */
`default_nettype none
module crp_supervisor_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic enable_i,
    input wire logic supply_ok_i,
    input wire logic dynamic_voltage_change_up_i,
    input wire logic [2:0] per_phase_overcurrent_trip_i,
    input wire logic other_rail_fault_i,
    input wire logic [2:0] high_side_on_o,
    input wire logic [2:0] low_side_on_o,
    input wire logic other_rail_shutdown_o,
    input wire logic soft_shutdown_o,
    input wire logic force_three_phase_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic off;
    assign off = high_side_on_o == 3'h0 && low_side_on_o == 3'h0;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_enable_off: assert property (!enable_i |=> off)
        else $error("gates on while disabled");
    a_phase_oc_off: assert property (|per_phase_overcurrent_trip_i |-> ##[1:3] off)
        else $error("gates on after phase trip");
    a_soft_follow: assert property (##1 soft_shutdown_o == $past(other_rail_fault_i))
        else $error("soft shutdown wrong");
    a_fault_hold: assert property ((other_rail_shutdown_o && enable_i && supply_ok_i)[*3]
        |=> other_rail_shutdown_o) else $error("fault latch lost");
    a_fault_high_off: assert property (other_rail_shutdown_o |-> high_side_on_o == 3'h0)
        else $error("high side on in fault");
    a_three_phase: assert property (dynamic_voltage_change_up_i |-> ##2 force_three_phase_o)
        else $error("no three phase");
    c_ack: cover property (wb_ack_o);
    c_fault: cover property ($rose(other_rail_shutdown_o));
    c_three: cover property ($rose(force_three_phase_o));
endmodule // crp_supervisor_props
bind crp_supervisor crp_supervisor_props i_crp_supervisor_props (.*);
`default_nettype wire

// >>> verif/crp_supervisor_test.sv
/* Self-checking bench for the supervisor.
   Assumes the stage model and the bound checker. */
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %h", $time, a); end end
module crp_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import crp_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, enable_i, supply_ok_i;
    logic [7:0] wb_adr_i, on_time_cyc_i;
    logic [3:0] wb_sel_i, voltage_change_comp_bits_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic core_external_shift_enable_i, second_rail_external_shift_enable_i, ramp_dem_o;
    logic [11:0] core_offset_input_i, second_rail_offset_input_i;
    logic [1:0] config_strap_a_i, config_strap_b_i, ramp_amplitude_o;
    logic dynamic_voltage_change_up_i, dynamic_voltage_change_down_i, quick_response_i;
    logic dynamic_voltage_change_done_i, diode_emulation_mode_i, other_rail_fault_i;
    logic [2:0] active_phases_i, per_phase_overcurrent_trip_i, pwm_high_i, pwm_low_i;
    logic [2:0] high_side_on_o, low_side_on_o, on_time_override_o;
    logic [13:0] current_monitor_pin_i;
    logic [8:0] cycle_current_i, output_current_o;
    logic signed [15:0] output_sense_pin_i, reference_i, voltage_code_i;
    logic signed [15:0] core_offset_o, second_rail_offset_o;
    logic overcurrent_alert_n_o, other_rail_shutdown_o, soft_shutdown_o, force_three_phase_o;
    int err_count, samples_checked;
    // Monitor input in quarter mV, then expected code
    logic [22:0] rows [5] = '{{14'h0000, 9'h000}, {14'h0019, 9'h001},
        {14'h31e6, 9'h1fe}, {14'h31e7, 9'h1ff}, {14'h3fff, 9'h1ff}};
    crp_supervisor i_crp_supervisor (.*);
    crp_stage_model i_crp_stage_model (.pwm_high_o(pwm_high_i), .pwm_low_o(pwm_low_i),
        .phases_o(active_phases_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task give_verdict;
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin
            tick(1);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        tick(1);
        if (n >= 20) begin
            err_count++;
            give_verdict();
        end
    endtask
    task renable;
        enable_i <= 1'b0;
        tick(2);
        enable_i <= 1'b1;
        tick(3);
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, enable_i, cycle_current_i,
            dynamic_voltage_change_up_i, dynamic_voltage_change_down_i, quick_response_i,
            dynamic_voltage_change_done_i, diode_emulation_mode_i, other_rail_fault_i,
            per_phase_overcurrent_trip_i, current_monitor_pin_i} = '0;
        {rst_i, supply_ok_i, core_external_shift_enable_i} = 3'h7;
        second_rail_external_shift_enable_i = 1'b1;
        {wb_sel_i, on_time_cyc_i, config_strap_a_i, config_strap_b_i} = 16'hf089;
        {core_offset_input_i, second_rail_offset_input_i} = {2{12'h514}};
        {output_sense_pin_i, reference_i, voltage_code_i} = {3{16'sh03e8}};
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        `CHK(overcurrent_alert_n_o, 1'b1)
        wb(1'b0, ADR_OC_CFG, 32'h0);
        `CHK(rd, 32'h0003_01ff)
        wb(1'b0, 8'h20, 32'h0);
        `CHK(rd, 32'h0)
        renable();
        `CHK({core_offset_o, second_rail_offset_o}, 32'h0064_0064)
        `CHK({voltage_change_comp_bits_o, ramp_amplitude_o}, 6'h1f)
        foreach (rows[i]) begin
            current_monitor_pin_i <= rows[i][22:9];
            tick(210);
            `CHK(output_current_o, rows[i][8:0])
        end
        current_monitor_pin_i <= 14'h0000;
        {dynamic_voltage_change_up_i, quick_response_i} <= 2'h3;
        tick(1);
        {dynamic_voltage_change_up_i, quick_response_i} <= 2'h0;
        tick(3);
        `CHK({force_three_phase_o, on_time_override_o}, 4'hf)
        wb(1'b1, ADR_OC_CFG, 32'h0003_0064);
        cycle_current_i <= 9'h0c8;
        tick(3);
        `CHK({overcurrent_alert_n_o, high_side_on_o}, 4'h5)
        tick(620);
        `CHK({high_side_on_o, low_side_on_o}, 6'h00)
        cycle_current_i <= 9'h000;
        renable();
        `CHK(overcurrent_alert_n_o, 1'b1)
        output_sense_pin_i <= 16'sh052d;
        tick(120);
        output_sense_pin_i <= 16'sh052e;
        tick(50);
        output_sense_pin_i <= 16'sh03e8;
        tick(5);
        `CHK(other_rail_shutdown_o, 1'b0)
        output_sense_pin_i <= 16'sh052e;
        tick(110);
        `CHK({other_rail_shutdown_o, high_side_on_o, low_side_on_o}, 7'h47)
        {output_sense_pin_i, other_rail_fault_i} <= {16'shfffb, 1'b1};
        tick(3);
        `CHK({soft_shutdown_o, low_side_on_o}, 4'h8)
        {output_sense_pin_i, other_rail_fault_i} <= {16'sh0005, 1'b0};
        tick(3);
        `CHK(low_side_on_o, 3'h7)
        renable();
        output_sense_pin_i <= 16'sh01f4;
        tick(290);
        `CHK(other_rail_shutdown_o, 1'b0)
        tick(20);
        `CHK({other_rail_shutdown_o, high_side_on_o, low_side_on_o}, 7'h40)
        output_sense_pin_i <= 16'sh03e8;
        core_offset_input_i <= 12'h0c8;
        renable();
        per_phase_overcurrent_trip_i <= 3'h2;
        tick(3);
        `CHK({high_side_on_o, low_side_on_o}, 6'h00)
        {current_monitor_pin_i, diode_emulation_mode_i} <= {14'h0c80, 1'b1};
        tick(900);
        `CHK({overcurrent_alert_n_o, ramp_dem_o}, 2'h3)
        supply_ok_i <= 1'b0;
        tick(250);
        `CHK(overcurrent_alert_n_o, 1'b0)
        tick(60);
        wb(1'b0, ADR_STATUS, 32'h0);
        `CHK({rd[9], rd[6]}, 2'h1)
        give_verdict();
    end
endmodule // crp_supervisor_test
`default_nettype wire
